// ===== inc/dsrf_pkg.sv
`default_nettype none
package dsrf_pkg;
    // Special register numbers, decimal as decoded by the move instructions
    localparam logic [9:0] SPR_IA_A   = 10'd144;
    localparam logic [9:0] SPR_IA_B   = 10'd145;
    localparam logic [9:0] SPR_IA_C   = 10'd146;
    localparam logic [9:0] SPR_IA_D   = 10'd147;
    localparam logic [9:0] SPR_ECAUSE = 10'd148;
    localparam logic [9:0] SPR_DEN    = 10'd149;
    localparam logic [9:0] SPR_CNT_1  = 10'd150;
    localparam logic [9:0] SPR_CNT_2  = 10'd151;
    localparam logic [9:0] SPR_LS_E   = 10'd152;
    localparam logic [9:0] SPR_LS_F   = 10'd153;
    localparam logic [9:0] SPR_DC_G   = 10'd154;
    localparam logic [9:0] SPR_DC_H   = 10'd155;
    localparam logic [9:0] SPR_LCTL_1 = 10'd156;
    localparam logic [9:0] SPR_LCTL_2 = 10'd157;
    localparam logic [9:0] SPR_FCTL   = 10'd158;
    localparam logic [9:0] SPR_BADDR  = 10'd159;
    localparam logic [9:0] SPR_DPDATA = 10'd630;
    // First index of the contiguous block 144..159
    localparam logic [9:0] SPR_BASE   = 10'd144;
    localparam int         NUM_BANK   = 16;
    // Register bank indices that need special treatment
    localparam logic [3:0] IDX_IA_LAST = 4'h3;
    localparam logic [3:0] IDX_ECAUSE  = 4'h4;
    localparam logic [3:0] IDX_FCTL    = 4'hE;
    // Reserved low-order bits 30:31 of the instruction address comparators
    localparam logic [31:0] IA_FIELD_MASK = 32'hFFFFFFFC;
    localparam logic [31:0] FCTL_RESET    = 32'h00000000;
    // Show cycle control sits in big-endian bits 30:31, i.e. [1:0]
    localparam int          SHOW_LSB      = 0;
    localparam logic [31:0] INDET_DATA    = 32'h00000000;
    // Instruction retirements until a new show cycle setting applies
    localparam logic [1:0]  SHOW_DELAY    = 2'h2;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [9:0]  spr;
        logic [31:0] wdata;
    } dsrf_req_s;

    typedef struct packed {
        logic        prog_exc;
        logic        done;
        logic [31:0] rdata;
    } dsrf_rsp_s;
endpackage
`default_nettype wire

// ===== logic/dsrf_regfile.sv
`timescale 1ns/100ps
`default_nettype none
module dsrf_regfile
    import dsrf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire dsrf_req_s   req,
    input  wire logic        priv_user,
    input  wire logic        dbg_enable,
    input  wire logic        in_debug,
    input  wire logic [31:0] cause_events,
    input  wire logic [31:0] devport_load,
    input  wire logic        devport_load_en,
    input  wire logic        instr_retire,
    output var  dsrf_rsp_s   rsp,
    output logic [31:0]      debug_enable_mask,
    output logic [31:0]      exception_cause,
    output logic [31:0]      fetch_bus_support_ctrl,
    output logic [1:0]       fetch_show_cycle_control
);

    logic [31:0] bank_q [NUM_BANK];
    logic [31:0] dpdata_q;
    logic [31:0] fctl_q;
    logic [31:0] ecause_q;
    logic [1:0]  show_q;
    logic [1:0]  show_pend_q;
    logic [1:0]  show_cnt_q;
    dsrf_rsp_s   rsp_q;

    // Decode: hit in the contiguous bank and its index
    function automatic logic in_bank(input logic [9:0] n);
        in_bank = (n >= SPR_BASE) && (n <= SPR_BADDR);
    endfunction

    function automatic logic [3:0] bank_idx(input logic [9:0] n);
        logic [9:0] d;
        d = n - SPR_BASE;
        bank_idx = d[3:0];
    endfunction

    logic       hit;
    logic       is_dp;
    logic [3:0] idx;
    logic       wr_ok;
    logic       rd_ok;
    logic       clr_ok;

    assign is_dp  = (req.spr == SPR_DPDATA);
    assign hit    = in_bank(req.spr) || is_dp;
    assign idx    = bank_idx(req.spr);
    // Writes only in supervisor state and when debug is off or entered
    assign wr_ok  = req.wr && hit && !priv_user && (!dbg_enable || in_debug);
    assign rd_ok  = req.rd && hit && !priv_user;
    assign clr_ok = rd_ok && !is_dp && idx == IDX_ECAUSE
                    && (!dbg_enable || in_debug);

    // Comparator and control bank; left uninitialised to save reset fan-out
    always_ff @(posedge mclk) begin
        if (wr_ok && !is_dp && idx != IDX_ECAUSE && idx != IDX_FCTL) begin
            if (idx <= IDX_IA_LAST)
                bank_q[idx] <= req.wdata & IA_FIELD_MASK;
            else
                bank_q[idx] <= req.wdata;
        end
    end

    // Fetch bus control and the cause register are the only bank registers with a reset value
    // Kept out of the bank so that the array has a single writing process
    always_ff @(posedge mclk) begin
        if (!rst_n)
            fctl_q <= FCTL_RESET;
        else if (wr_ok && !is_dp && idx == IDX_FCTL)
            fctl_q <= req.wdata;
    end

    // Cause register: events set bits, a set wins over a clear-on-read
    always_ff @(posedge mclk) begin
        if (!rst_n)
            ecause_q <= 32'h00000000;
        else if (clr_ok)
            ecause_q <= cause_events;
        else
            ecause_q <= ecause_q | cause_events;
    end

    // Port data: software writes only in debug mode, the port may load it
    always_ff @(posedge mclk) begin
        if (devport_load_en)
            dpdata_q <= devport_load;
        else if (wr_ok && is_dp && in_debug)
            dpdata_q <= req.wdata;
    end

    // Show cycle control lags the register by two retired instructions
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            show_q      <= 2'h0;
            show_pend_q <= 2'h0;
            show_cnt_q  <= 2'h0;
        end else if (wr_ok && !is_dp && idx == IDX_FCTL) begin
            show_pend_q <= req.wdata[SHOW_LSB +: 2];
            show_cnt_q  <= SHOW_DELAY;
        end else if (show_cnt_q != 2'h0 && instr_retire) begin
            show_cnt_q <= show_cnt_q - 2'h1;
            if (show_cnt_q == 2'h1)
                show_q <= show_pend_q;
        end
    end

    // Registered answer; one cycle after the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q.prog_exc <= (req.rd || req.wr) && hit && priv_user;
            rsp_q.done     <= (req.rd || req.wr) && hit && !priv_user;
            if (!rd_ok)
                rsp_q.rdata <= 32'h00000000;
            else if (is_dp)
                rsp_q.rdata <= in_debug ? dpdata_q : INDET_DATA;
            else if (idx == IDX_ECAUSE)
                rsp_q.rdata <= ecause_q;
            else if (idx == IDX_FCTL)
                rsp_q.rdata <= fctl_q;
            else
                rsp_q.rdata <= bank_q[idx];
        end
    end

    // Mirror outputs of the steering registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            debug_enable_mask        <= 32'h00000000;
            exception_cause          <= 32'h00000000;
            fetch_bus_support_ctrl   <= 32'h00000000;
            fetch_show_cycle_control <= 2'h0;
        end else begin
            debug_enable_mask        <= (wr_ok && !is_dp && idx == bank_idx(SPR_DEN)) ? req.wdata
                                        : debug_enable_mask;
            exception_cause          <= ecause_q;
            fetch_bus_support_ctrl   <= fctl_q;
            fetch_show_cycle_control <= show_q;
        end
    end

    assign rsp = rsp_q;

    // Checks
    property p_user_exc;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && hit && priv_user) |=> rsp.prog_exc && !rsp.done;
    endproperty
    a_user_exc: assert property (p_user_exc) else $error("user write no exception");

    property p_user_rd;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && hit && priv_user) |=> rsp.prog_exc && rsp.rdata == 32'h00000000;
    endproperty
    a_user_rd: assert property (p_user_rd) else $error("user read performed");

    property p_no_clr;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.spr == SPR_ECAUSE && dbg_enable && !in_debug && ecause_q != 0)
        |=> ecause_q != 32'h00000000;
    endproperty
    a_no_clr: assert property (p_no_clr) else $error("cause cleared wrongly");

    property p_dp_ignored;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && is_dp && !in_debug && !devport_load_en) |=> $stable(dpdata_q);
    endproperty
    a_dp_ignored: assert property (p_dp_ignored) else $error("port data written");

    property p_dp_indet;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && is_dp && !priv_user && !in_debug) |=> rsp.rdata == INDET_DATA;
    endproperty
    a_dp_indet: assert property (p_dp_indet) else $error("port data leaked");

    property p_ia_resv;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && !priv_user && req.spr >= SPR_IA_A && req.spr <= SPR_IA_D)
        |=> rsp.rdata[1:0] == 2'h0;
    endproperty
    a_ia_resv: assert property (p_ia_resv) else $error("reserved bits set");

    sequence s_show_wr;
        wr_ok && !is_dp && idx == IDX_FCTL;
    endsequence
    property p_show_hold;
        @(posedge mclk) disable iff (!rst_n)
        s_show_wr ##1 (!wr_ok && instr_retire) |=> $stable(show_q);
    endproperty
    a_show_hold: assert property (p_show_hold) else $error("show control early");

    property p_den_locked;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && req.spr == SPR_DEN && dbg_enable && !in_debug)
        |=> $stable(debug_enable_mask);
    endproperty
    a_den_locked: assert property (p_den_locked) else $error("locked write done");

    // Numbers outside the two decoded ranges get no answer at all
    property p_unmapped;
        @(posedge mclk) disable iff (!rst_n)
        ((req.rd || req.wr) && req.spr != SPR_DPDATA
         && (req.spr < SPR_IA_A || req.spr > SPR_BADDR))
        |=> !rsp.done && !rsp.prog_exc;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped number answered");

    property p_clr_rd;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.spr == SPR_ECAUSE && !priv_user && (!dbg_enable || in_debug))
        |=> ecause_q == $past(cause_events);
    endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("cause not cleared on read");

    property p_cause_rd;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.spr == SPR_ECAUSE && !priv_user)
        |=> rsp.done && rsp.rdata == $past(ecause_q);
    endproperty
    a_cause_rd: assert property (p_cause_rd) else $error("cause read wrong");

    // A software write never touches the cause bits, only events do
    property p_cause_wr;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && !req.rd && req.spr == SPR_ECAUSE)
        |=> ecause_q == ($past(ecause_q) | $past(cause_events));
    endproperty
    a_cause_wr: assert property (p_cause_wr) else $error("cause written");

    property p_user_keep;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.spr == SPR_ECAUSE && priv_user)
        |=> ecause_q == ($past(ecause_q) | $past(cause_events));
    endproperty
    a_user_keep: assert property (p_user_keep) else $error("user read cleared cause");

    property p_dp_valid;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.spr == SPR_DPDATA && !priv_user && in_debug)
        |=> rsp.done && rsp.rdata == $past(dpdata_q);
    endproperty
    a_dp_valid: assert property (p_dp_valid) else $error("port data read wrong");

    property p_den_write;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && req.spr == SPR_DEN && !priv_user && (!dbg_enable || in_debug))
        |=> debug_enable_mask == $past(req.wdata);
    endproperty
    a_den_write: assert property (p_den_write) else $error("mask write lost");

    property p_den_user;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && req.spr == SPR_DEN && priv_user)
        |=> $stable(debug_enable_mask);
    endproperty
    a_den_user: assert property (p_den_user) else $error("user write changed mask");

    property p_dp_user;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && req.spr == SPR_DPDATA && priv_user && !devport_load_en)
        |=> $stable(dpdata_q);
    endproperty
    a_dp_user: assert property (p_dp_user) else $error("user write changed port data");

    property p_ia_write;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && req.spr == SPR_IA_B && !priv_user && (!dbg_enable || in_debug))
        |=> bank_q[bank_idx(SPR_IA_B)] == {$past(req.wdata[31:2]), 2'h0};
    endproperty
    a_ia_write: assert property (p_ia_write) else $error("address comparator wrong");

    property p_ls_write;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && req.spr == SPR_LS_F && !priv_user && (!dbg_enable || in_debug))
        |=> bank_q[bank_idx(SPR_LS_F)] == $past(req.wdata);
    endproperty
    a_ls_write: assert property (p_ls_write) else $error("load store comparator wrong");

    property p_dc_write;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && req.spr == SPR_DC_G && !priv_user && (!dbg_enable || in_debug))
        |=> bank_q[bank_idx(SPR_DC_G)] == $past(req.wdata);
    endproperty
    a_dc_write: assert property (p_dc_write) else $error("data comparator wrong");

    // Two retirements straight after the write bring the new setting in
    sequence s_ret;
        !wr_ok && instr_retire;
    endsequence
    property p_show_take;
        @(posedge mclk) disable iff (!rst_n)
        s_show_wr ##1 s_ret ##1 s_ret
        |=> show_q == $past(req.wdata[SHOW_LSB +: 2], 3);
    endproperty
    a_show_take: assert property (p_show_take) else $error("show control late");

endmodule
`default_nettype wire

// ===== test/test_debug_support_register_file.sv
`timescale 1ns/100ps
`default_nettype none
module test_debug_support_register_file
    import dsrf_pkg::*;
;
    logic        mclk;
    logic        rst_n;
    dsrf_req_s   req;
    logic        priv_user;
    logic        dbg_enable;
    logic        in_debug;
    logic [31:0] cause_events;
    logic [31:0] devport_load;
    logic        devport_load_en;
    logic        instr_retire;
    dsrf_rsp_s   rsp;
    logic [31:0] den_mask;
    logic [31:0] cause;
    logic [31:0] fctl;
    logic [1:0]  show;
    int          errors;
    int          check_count;
    logic [31:0] d;
    logic [1:0]  st;

    dsrf_regfile dsrf_regfile_inst (
        .mclk                     (mclk),
        .rst_n                    (rst_n),
        .req                      (req),
        .priv_user                (priv_user),
        .dbg_enable               (dbg_enable),
        .in_debug                 (in_debug),
        .cause_events             (cause_events),
        .devport_load             (devport_load),
        .devport_load_en          (devport_load_en),
        .instr_retire             (instr_retire),
        .rsp                      (rsp),
        .debug_enable_mask        (den_mask),
        .exception_cause          (cause),
        .fetch_bus_support_ctrl   (fctl),
        .fetch_show_cycle_control (show)
    );

    // 20 MHz core clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic close_out();
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Answer lands on the first edge after the request; the task still watches two cycles
    task automatic acc(input logic r, input logic w, input logic [9:0] n, input logic [31:0] wd);
        req = {r, w, n, wd};
        @(negedge mclk);
        req = '0;
        st = 2'h0;
        d = 32'h0;
        repeat (2) begin
            if (rsp.done === 1'b1 || rsp.prog_exc === 1'b1) begin
                st = {rsp.prog_exc, rsp.done};
                d = rsp.rdata;
            end
            @(negedge mclk);
        end
    endtask

    // Comparators are undefined after reset, so every read follows a write
    task automatic wrchk(input logic [9:0] n, input logic [31:0] wd, input logic [31:0] e);
        acc(1'b0, 1'b1, n, wd);
        chk("write status", {30'h0, st}, 32'h1);
        acc(1'b1, 1'b0, n, 32'h0);
        chk("read data", d, e);
    endtask

    task automatic cev(input logic [31:0] v);
        cause_events = v;
        @(negedge mclk);
        cause_events = 32'h0;
    endtask

    task automatic retire();
        instr_retire = 1'b1;
        @(negedge mclk);
        instr_retire = 1'b0;
        repeat (3) @(negedge mclk);
    endtask

    // Guard against a hung handshake
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        close_out();
    end

    initial begin
        {rst_n, req, priv_user, dbg_enable, in_debug, cause_events} = '0;
        {devport_load, devport_load_en, instr_retire, errors, check_count} = '0;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        chk("fetch ctrl reset", fctl, FCTL_RESET);
        wrchk(SPR_IA_A, 32'hFFFFFFFF, 32'hFFFFFFFC);
        wrchk(SPR_IA_D, 32'h12345677, 32'h12345674);
        wrchk(SPR_LS_E, 32'hFFFFFFFF, 32'hFFFFFFFF);
        wrchk(SPR_LS_F, 32'h0123456B, 32'h0123456B);
        wrchk(SPR_DC_G, 32'h89ABCDEF, 32'h89ABCDEF);
        wrchk(SPR_DC_H, 32'hFFFF0003, 32'hFFFF0003);
        wrchk(SPR_IA_B, 32'h76543213, 32'h76543210);
        wrchk(SPR_IA_C, 32'h00000002, 32'h00000000);
        wrchk(SPR_CNT_1, 32'h0000FFFF, 32'h0000FFFF);
        wrchk(SPR_CNT_2, 32'hFFFF0000, 32'hFFFF0000);
        wrchk(SPR_LCTL_1, 32'h13579BDF, 32'h13579BDF);
        wrchk(SPR_LCTL_2, 32'h2468ACE0, 32'h2468ACE0);
        wrchk(SPR_BADDR, 32'h0F0F1230, 32'h0F0F1230);
        wrchk(SPR_DEN, 32'hA5A55A5A, 32'hA5A55A5A);
        chk("mask port", den_mask, 32'hA5A55A5A);
        acc(1'b0, 1'b1, 10'h08F, 32'h1);
        chk("unmapped status", {30'h0, st}, 32'h0);
        acc(1'b1, 1'b0, 10'h0A0, 32'h0);
        chk("unmapped read", {30'h0, st}, 32'h0);
        acc(1'b0, 1'b1, 10'h277, 32'h1);
        chk("unmapped port", {30'h0, st}, 32'h0);
        cev(32'h00000011);
        acc(1'b0, 1'b1, SPR_ECAUSE, 32'hFFFFFFFF);
        chk("cause kept", cause, 32'h00000011);
        acc(1'b1, 1'b0, SPR_ECAUSE, 32'h0);
        chk("cause read", d, 32'h00000011);
        chk("cause cleared", cause, 32'h0);
        // Enabled but not entered: reads keep the cause, writes drop
        dbg_enable = 1'b1;
        cev(32'h00000022);
        acc(1'b1, 1'b0, SPR_ECAUSE, 32'h0);
        chk("cause read", d, 32'h00000022);
        chk("cause held", cause, 32'h00000022);
        acc(1'b0, 1'b1, SPR_DEN, 32'h0);
        chk("mask unchanged", den_mask, 32'hA5A55A5A);
        acc(1'b0, 1'b1, SPR_LS_E, 32'h0);
        acc(1'b1, 1'b0, SPR_LS_E, 32'h0);
        chk("locked comparator", d, 32'hFFFFFFFF);
        acc(1'b1, 1'b0, SPR_DPDATA, 32'h0);
        chk("port read status", {30'h0, st}, 32'h1);
        chk("port data outside", d, INDET_DATA);
        // Entered debug: cause clears, writes land, port data valid
        in_debug = 1'b1;
        acc(1'b1, 1'b0, SPR_ECAUSE, 32'h0);
        chk("cause cleared", cause, 32'h0);
        wrchk(SPR_DEN, 32'h0000F00F, 32'h0000F00F);
        wrchk(SPR_DPDATA, 32'hCAFE0001, 32'hCAFE0001);
        dbg_enable = 1'b0;
        in_debug = 1'b0;
        acc(1'b0, 1'b1, SPR_DPDATA, 32'h0BAD0BAD);
        in_debug = 1'b1;
        acc(1'b1, 1'b0, SPR_DPDATA, 32'h0);
        chk("port data kept", d, 32'hCAFE0001);
        devport_load = 32'h5EED1234;
        devport_load_en = 1'b1;
        @(negedge mclk);
        devport_load_en = 1'b0;
        acc(1'b1, 1'b0, SPR_DPDATA, 32'h0);
        chk("port data loaded", d, 32'h5EED1234);
        // User state refuses every access whatever the debug state
        priv_user = 1'b1;
        cev(32'h00000044);
        for (int k = 0; k < 4; k++) begin
            {dbg_enable, in_debug} = k[1:0];
            acc(1'b0, 1'b1, SPR_DEN, 32'h0);
            chk("user write status", {30'h0, st}, 32'h2);
            chk("user write mask", den_mask, 32'h0000F00F);
            acc(1'b1, 1'b0, SPR_ECAUSE, 32'h0);
            chk("user read status", {30'h0, st}, 32'h2);
            chk("user read data", d, 32'h0);
            chk("user cause", cause, 32'h00000044);
        end
        {priv_user, dbg_enable, in_debug} = 3'h0;
        // Show control lags by two retired instructions
        acc(1'b0, 1'b1, SPR_FCTL, 32'h00000003);
        @(negedge mclk);
        chk("fetch ctrl", fctl, 32'h00000003);
        retire();
        chk("show after one", {30'h0, show}, 32'h0);
        retire();
        chk("show after two", {30'h0, show}, 32'h3);
        // Write followed at once by two retirements in a row
        req = {1'b0, 1'b1, SPR_FCTL, 32'h00000001};
        @(negedge mclk);
        req = '0;
        instr_retire = 1'b1;
        repeat (2) @(negedge mclk);
        instr_retire = 1'b0;
        repeat (2) @(negedge mclk);
        chk("show back to back", {30'h0, show}, 32'h1);
        acc(1'b1, 1'b0, SPR_FCTL, 32'h0);
        chk("fetch ctrl read", d, 32'h00000001);
        close_out();
    end
endmodule
`default_nettype wire
